/* File: hw/sch_stack_cmd_map.vh */
// Register offsets, command codes and timing counts of the stack command handler.
// Included by the handler; holds definitions only.
`ifndef SCH_STACK_CMD_MAP_VH
`define SCH_STACK_CMD_MAP_VH

`define SCH_PAGE_CONFIG 3'h2
`define SCH_PAGE_CMD 3'h3
`define SCH_PAGE_NV_REF 3'h4
`define SCH_PAGE_NV_SHADOW 3'h5
`define SCH_OFS_NV_REF 6'h3F
`define SCH_OFS_NV_SHADOW 6'h00

`define SCH_CMD_FIRST 6'h01
`define SCH_CMD_IDENTIFY 6'h09
`define SCH_CMD_SLEEP 6'h0A
`define SCH_CMD_NAK 6'h0B
`define SCH_CMD_ACK 6'h0C
`define SCH_CMD_COMM_FAIL 6'h0E
`define SCH_CMD_WAKEUP 6'h0F
`define SCH_CMD_BAL_EN 6'h10
`define SCH_CMD_BAL_INH 6'h11
`define SCH_CMD_RESET 6'h12
`define SCH_CMD_CALC_SUM 6'h13
`define SCH_CMD_CHECK_SUM 6'h14

`define SCH_ADDR_ALL 4'hF
`define SCH_SUM_W 14
`define SCH_CFG_WORDS 8
`define SCH_SIG_POLY 14'h2837
`define SCH_SUM_RESET 14'h0000

`define SCH_CLK_PERIOD_NS 4
`define SCH_WAKE_HALF_NS 4000
`define SCH_WAKE_HALF_CYC (`SCH_WAKE_HALF_NS / `SCH_CLK_PERIOD_NS)
`define SCH_WAKE_TOGGLES 5'h10
`define SCH_WAKE_EDGES 4
`define SCH_FWD_TIMEOUT_NS 10000
`define SCH_FWD_TIMEOUT_CYC (`SCH_FWD_TIMEOUT_NS / `SCH_CLK_PERIOD_NS)
`define SCH_WDOG_CYC 250000

`endif

/* File: hw/sch_stack_cmd.v */
// Device command handler of one stacked battery monitor: decodes command frames,
// answers, forwards up the chain, wakes the stack and keeps the checksum registers.
// Assumes a same-clock frame decoder in front; link and strap pins are asynchronous.
// Function
// - Unrecognised communication answers not-acknowledge code
// - Acknowledge command answers acknowledge, changes nothing
// - Silent upstream device yields communications-failure answer
// - Devices beyond fault learn it by watchdog
// - Master wakes stack with slow clock upward
// - Top device answers acknowledge once awake
// - Balance enable sets bit, broadcast allowed
// - Balance inhibit clears bit, broadcast allowed
// - Reset reloads nonvolatile image, halts activity
// - No volatile writes until identify after reset
// - Calculate command stores page-2 checksum
// - Check command mismatch sets register check fault
// - Every reload recomputes shadow checksum register
// - Read-only factory reference checksum register
// - Command page writes answer not-acknowledge
`include "sch_stack_cmd_map.vh"
`default_nettype none

module sch_stack_cmd #(
  parameter [13:0] NV_REF_SUM = 14'h1A5C, // Arbitrary factory reference value
  parameter [31:0] WDOG_CYC = `SCH_WDOG_CYC
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Straps (asynchronous pins)
  input wire [3:0] myDevAddr,
  input wire isMaster,
  input wire isTop,
  // Command frame from the decoder
  input wire cmdValid,
  input wire cmdWrite,
  input wire [3:0] cmdDevAddr,
  input wire [2:0] cmdPage,
  input wire [5:0] cmdAddr,
  input wire [13:0] cmdWdata,
  // Answer toward the host
  output reg rspValid_ff,
  output reg [5:0] rspCode_ff,
  output reg [13:0] rspData_ff,
  // Frame forwarded up the chain
  output reg fwdValid_ff,
  // Upstream link pins
  input wire upLinkClk,
  input wire upLinkAck,
  output reg wakeClkOut_ff,
  // Downstream wake clock pin
  input wire dnWakeClk,
  // Device state
  output reg cellBalanceOn_ff,
  output reg registerCheckFault_ff,
  output reg scanHalt_ff,
  output reg asleep_ff,
  output reg watchdogFault_ff
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_LOAD = 5'h02;
  localparam [4:0] ST_CALC = 5'h04;
  localparam [4:0] ST_CHECK = 5'h08;
  localparam [4:0] ST_FWD = 5'h10;
  localparam [15:0] WAKE_HALF = `SCH_WAKE_HALF_CYC;
  localparam [15:0] FWD_TIMEOUT = `SCH_FWD_TIMEOUT_CYC;
  // Same shift register for stored and shadow sums
  function [13:0] sigStep;
    input [13:0] sum;
    input [13:0] word;
    begin
      sigStep = {sum[12:0], 1'b0} ^ (sum[13] ? `SCH_SIG_POLY : 14'h0000) ^ word;
    end
  endfunction
  // Factory configuration image held in nonvolatile memory, word 0 lowest
  localparam [111:0] NV_IMAGE = {14'h2020, 14'h1010, 14'h0DEF, 14'h0ABC,
    14'h0789, 14'h0456, 14'h0123, 14'h0000};
  // Two-flop synchronisers for every asynchronous pin
  reg [8:0] syncA_ff;
  reg [8:0] syncB_ff;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      syncA_ff <= 9'h000;
      syncB_ff <= 9'h000;
    end else begin
      syncA_ff <= {dnWakeClk, upLinkAck, upLinkClk, isTop, isMaster, myDevAddr};
      syncB_ff <= syncA_ff;
    end
  end
  wire [3:0] devAddr = syncB_ff[3:0];
  wire master = syncB_ff[4];
  wire top = syncB_ff[5];
  wire upClkS = syncB_ff[6];
  wire upAckS = syncB_ff[7];
  wire dnWakeS = syncB_ff[8];
  reg upClkPrev_ff;
  reg dnWakePrev_ff;
  reg [4:0] state_ff;
  reg [2:0] idx_ff;
  reg [13:0] sum_ff;
  reg [13:0] shadowSum_ff;
  reg [13:0] storedSum_ff;
  reg [8 * 14 - 1:0] cfg_ff;
  reg identified_ff;
  reg [15:0] timer_ff;
  reg [4:0] wakeToggles_ff;
  reg [2:0] wakeEdges_ff;
  reg [31:0] wdog_ff;
  wire upAckSeen = upClkS && !upClkPrev_ff && upAckS;
  wire dnWakeEdge = dnWakeS && !dnWakePrev_ff;
  wire forMe = (cmdDevAddr == devAddr) || (cmdDevAddr == `SCH_ADDR_ALL);
  wire bcast = (cmdDevAddr == `SCH_ADDR_ALL);
  wire [13:0] cfgWord = cfg_ff[idx_ff * 14 +: 14];
  wire [13:0] sumNext = sigStep(sum_ff, state_ff[1] ? NV_IMAGE[idx_ff * 14 +: 14] : cfgWord);
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      upClkPrev_ff <= 1'b0;
      dnWakePrev_ff <= 1'b0;
      state_ff <= ST_LOAD;
      idx_ff <= 3'h0;
      sum_ff <= `SCH_SUM_RESET;
      shadowSum_ff <= `SCH_SUM_RESET;
      storedSum_ff <= `SCH_SUM_RESET;
      cfg_ff <= {(8 * 14){1'b0}};
      identified_ff <= 1'b0;
      timer_ff <= 16'h0000;
      wakeToggles_ff <= 5'h00;
      wakeEdges_ff <= 3'h0;
      wdog_ff <= 32'h00000000;
      rspValid_ff <= 1'b0;
      rspCode_ff <= 6'h00;
      rspData_ff <= 14'h0000;
      fwdValid_ff <= 1'b0;
      wakeClkOut_ff <= 1'b0;
      cellBalanceOn_ff <= 1'b0;
      registerCheckFault_ff <= 1'b0;
      scanHalt_ff <= 1'b0;
      asleep_ff <= 1'b0;
      watchdogFault_ff <= 1'b0;
    end else begin
      upClkPrev_ff <= upClkS;
      dnWakePrev_ff <= dnWakeS;
      rspValid_ff <= 1'b0;
      fwdValid_ff <= 1'b0;
      scanHalt_ff <= 1'b0;
      // Any traffic feeds the watchdog; cut-off devices see it expire
      if (cmdValid || dnWakeEdge) begin
        wdog_ff <= 32'h00000000;
      end else if (wdog_ff >= WDOG_CYC - 1) begin
        watchdogFault_ff <= 1'b1;
      end else begin
        wdog_ff <= wdog_ff + 32'h00000001;
      end
      // Master drives a slow clock up the chain while waking
      if (wakeToggles_ff != 5'h00) begin
        if (timer_ff >= WAKE_HALF - 1) begin
          timer_ff <= 16'h0000;
          wakeClkOut_ff <= ~wakeClkOut_ff;
          wakeToggles_ff <= wakeToggles_ff - 5'h01;
        end else begin
          timer_ff <= timer_ff + 16'h0001;
        end
      end
      // Sleeping devices count wake edges from below
      if (asleep_ff && dnWakeEdge) begin
        if (wakeEdges_ff == `SCH_WAKE_EDGES - 1) begin
          asleep_ff <= 1'b0;
          wakeEdges_ff <= 3'h0;
          watchdogFault_ff <= 1'b0;
          if (top) begin
            rspValid_ff <= 1'b1;
            rspCode_ff <= `SCH_CMD_ACK;
            rspData_ff <= 14'h0000;
          end
        end else begin
          wakeEdges_ff <= wakeEdges_ff + 3'h1;
        end
      end
      case (state_ff)
        ST_LOAD: begin
          cfg_ff[idx_ff * 14 +: 14] <= NV_IMAGE[idx_ff * 14 +: 14];
          sum_ff <= sumNext;
          idx_ff <= idx_ff + 3'h1;
          if (idx_ff == 3'h7) begin
            shadowSum_ff <= sumNext;
            state_ff <= ST_IDLE;
          end
        end
        ST_CALC, ST_CHECK: begin
          sum_ff <= sumNext;
          idx_ff <= idx_ff + 3'h1;
          if (idx_ff == 3'h7) begin
            if (state_ff[2]) begin
              storedSum_ff <= sumNext;
            end else if (sumNext != storedSum_ff) begin
              registerCheckFault_ff <= 1'b1;
            end
            state_ff <= ST_IDLE;
            rspValid_ff <= !bcast;
            rspCode_ff <= state_ff[2] ? `SCH_CMD_CALC_SUM : `SCH_CMD_CHECK_SUM;
          end
        end
        ST_FWD: begin
          if (upAckSeen) begin
            state_ff <= ST_IDLE;
          end else if (timer_ff >= FWD_TIMEOUT - 1) begin
            state_ff <= ST_IDLE;
            timer_ff <= 16'h0000;
            rspValid_ff <= 1'b1;
            rspCode_ff <= `SCH_CMD_COMM_FAIL;
            rspData_ff <= 14'h0000;
          end else begin
            timer_ff <= timer_ff + 16'h0001;
          end
        end
        default: begin
          sum_ff <= `SCH_SUM_RESET;
          idx_ff <= 3'h0;
          if (cmdValid && !forMe) begin
            // Not ours: pass up and wait for the next device to answer
            fwdValid_ff <= 1'b1;
            timer_ff <= 16'h0000;
            state_ff <= ST_FWD;
          end else if (cmdValid) begin
            // Broadcast frames still go up so the whole stack acts together
            fwdValid_ff <= bcast && !top;
            rspValid_ff <= !bcast;
            rspData_ff <= 14'h0000;
            rspCode_ff <= `SCH_CMD_NAK;
            if (cmdPage == `SCH_PAGE_CMD) begin
              if (cmdWrite) begin
                rspCode_ff <= `SCH_CMD_NAK;
              end else if (cmdAddr == `SCH_CMD_ACK) begin
                rspCode_ff <= `SCH_CMD_ACK;
              end else if (cmdAddr == `SCH_CMD_BAL_EN) begin
                cellBalanceOn_ff <= 1'b1;
                rspCode_ff <= cmdAddr;
              end else if (cmdAddr == `SCH_CMD_BAL_INH) begin
                cellBalanceOn_ff <= 1'b0;
                rspCode_ff <= cmdAddr;
              end else if (cmdAddr == `SCH_CMD_RESET) begin
                cellBalanceOn_ff <= 1'b0;
                scanHalt_ff <= 1'b1;
                identified_ff <= 1'b0;
                registerCheckFault_ff <= 1'b0;
                state_ff <= ST_LOAD;
                rspCode_ff <= cmdAddr;
              end else if (cmdAddr == `SCH_CMD_CALC_SUM || cmdAddr == `SCH_CMD_CHECK_SUM) begin
                state_ff <= (cmdAddr == `SCH_CMD_CALC_SUM) ? ST_CALC : ST_CHECK;
                rspValid_ff <= 1'b0;
              end else if (cmdAddr == `SCH_CMD_WAKEUP) begin
                if (master) begin
                  wakeToggles_ff <= `SCH_WAKE_TOGGLES;
                  timer_ff <= 16'h0000;
                  asleep_ff <= 1'b0;
                  rspValid_ff <= 1'b0;
                end
              end else if (cmdAddr == `SCH_CMD_SLEEP) begin
                asleep_ff <= 1'b1;
                rspCode_ff <= cmdAddr;
              end else if (cmdAddr == `SCH_CMD_IDENTIFY) begin
                identified_ff <= 1'b1;
                rspCode_ff <= cmdAddr;
              end else if (cmdAddr >= `SCH_CMD_FIRST && cmdAddr < `SCH_CMD_IDENTIFY) begin
                rspCode_ff <= cmdAddr;
              end
            end else if (cmdPage == `SCH_PAGE_CONFIG && cmdAddr < 6'h08) begin
              rspCode_ff <= cmdAddr;
              if (!cmdWrite) begin
                rspData_ff <= cfg_ff[cmdAddr[2:0] * 14 +: 14];
              end else if (identified_ff) begin
                cfg_ff[cmdAddr[2:0] * 14 +: 14] <= cmdWdata;
              end else begin
                rspCode_ff <= `SCH_CMD_NAK;
              end
            end else if (cmdPage == `SCH_PAGE_NV_REF && cmdAddr == `SCH_OFS_NV_REF && !cmdWrite) begin
              rspCode_ff <= cmdAddr;
              rspData_ff <= NV_REF_SUM;
            end else if (cmdPage == `SCH_PAGE_NV_SHADOW && cmdAddr == `SCH_OFS_NV_SHADOW
                         && !cmdWrite) begin
              rspCode_ff <= cmdAddr;
              rspData_ff <= shadowSum_ff;
            end
          end
        end
      endcase
    end
  end

endmodule // sch_stack_cmd

`default_nettype wire

/* File: verification/sch_stack_cmd_sva.sv */
// Port checker of the stack command handler, bound to every handler instance.
// Assumes the handler's map header for command codes; one clock domain.
`include "sch_stack_cmd_map.vh"
`default_nettype none
module sch_stack_cmd_sva (
  // Clock, reset and frame
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [2:0] cmdPage,
  input wire logic [5:0] cmdAddr,
  // Outputs watched
  input wire logic rspValid_ff,
  input wire logic [5:0] rspCode_ff,
  input wire logic fwdValid_ff,
  input wire logic wakeClkOut_ff,
  input wire logic cellBalanceOn_ff,
  input wire logic registerCheckFault_ff,
  input wire logic scanHalt_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [11:0] fwdCnt_ff;
  logic [9:0] wakeCnt_ff;
  logic [3:0] chkCnt_ff;
  wire logic isCmd = cmdValid && !cmdWrite && cmdPage == `SCH_PAGE_CMD;
  // Counters saturate, so a long idle span never wraps into a false match
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fwdCnt_ff <= 12'hFFF;
      wakeCnt_ff <= 10'h3FF;
      chkCnt_ff <= 4'hF;
    end else begin
      fwdCnt_ff <= fwdValid_ff ? 12'h001 : fwdCnt_ff + {11'h000, ~&fwdCnt_ff};
      wakeCnt_ff <= $changed(wakeClkOut_ff) ? 10'h000 : wakeCnt_ff + {9'h000, ~&wakeCnt_ff};
      chkCnt_ff <= (isCmd && cmdAddr == `SCH_CMD_CHECK_SUM) ? 4'h0 : chkCnt_ff + {3'h0, ~&chkCnt_ff};
    end
  end
  a_nak_cause: assert property (rspValid_ff && rspCode_ff == `SCH_CMD_NAK |-> $past(cmdValid))
    else $error("NAK answer without a frame");
  a_cmd_write_nak: assert property (cmdValid && cmdWrite && cmdPage == `SCH_PAGE_CMD
    |=> !rspValid_ff || rspCode_ff == `SCH_CMD_NAK) else $error("command page write not NAK");
  a_ack_still: assert property (isCmd && cmdAddr == `SCH_CMD_ACK |=> $stable(cellBalanceOn_ff)
    && (!rspValid_ff || rspCode_ff == `SCH_CMD_ACK)) else $error("ACK changed state or code");
  a_bal_rise: assert property ($rose(cellBalanceOn_ff)
    |-> $past(isCmd && cmdAddr == `SCH_CMD_BAL_EN)) else $error("balance set without enable");
  a_bal_fall: assert property ($fell(cellBalanceOn_ff) |-> scanHalt_ff || $past(scanHalt_ff)
    || $past(isCmd && cmdAddr == `SCH_CMD_BAL_INH)) else $error("balance cleared without cause");
  a_reset_clears: assert property (scanHalt_ff |=> !cellBalanceOn_ff && !registerCheckFault_ff)
    else $error("reset left balance or fault");
  a_fault_cause: assert property ($rose(registerCheckFault_ff) |-> chkCnt_ff <= 4'hB)
    else $error("fault set without check");
  a_comm_fail: assert property (rspValid_ff && rspCode_ff == `SCH_CMD_COMM_FAIL
    |-> fwdCnt_ff == 12'd2500) else $error("comm fail answer at wrong time");
  a_wake_spacing: assert property ($changed(wakeClkOut_ff) |-> wakeCnt_ff >= 10'd999)
    else $error("wake clock half period short");
  c_nak: cover property (rspValid_ff && rspCode_ff == `SCH_CMD_NAK);
  c_fault: cover property ($rose(registerCheckFault_ff));
  c_comm_fail: cover property (rspValid_ff && rspCode_ff == `SCH_CMD_COMM_FAIL);
endmodule // sch_stack_cmd_sva
bind sch_stack_cmd sch_stack_cmd_sva sch_stack_cmd_sva_i (.clock(clock), .rst_n(rst_n),
  .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdPage(cmdPage), .cmdAddr(cmdAddr),
  .rspValid_ff(rspValid_ff), .rspCode_ff(rspCode_ff), .fwdValid_ff(fwdValid_ff),
  .wakeClkOut_ff(wakeClkOut_ff), .cellBalanceOn_ff(cellBalanceOn_ff),
  .registerCheckFault_ff(registerCheckFault_ff), .scanHalt_ff(scanHalt_ff));
`default_nettype wire

/* File: verification/sch_uplink_model.sv */
// Upstream neighbour: acknowledges a forwarded frame with a burst of link clock.
// Driven by the forward pulse; ackOn lets the bench make it stay silent.
`default_nettype none
module sch_uplink_model (
  // Control
  input wire logic fwdValid,
  input wire logic ackOn,
  // Link pins
  output logic linkClk,
  output logic linkAck
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    linkClk = 1'b0;
    linkAck = 1'b0;
  end
  // Clock stands still between frames; released ack line is pulled low
  always @(posedge fwdValid) begin
    if (ackOn) begin
      #300 linkAck = 1'b1;
      repeat (3) begin
        #62.5 linkClk = 1'b1;
        #62.5 linkClk = 1'b0;
      end
      linkAck = 1'b0;
    end
  end
endmodule // sch_uplink_model
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench of the stack command handler with an upstream neighbour model.
// Short watchdog; straps fixed for a one-device stack that is both bottom and top.
`include "sch_stack_cmd_map.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdWrite = 1'b0;
  logic [3:0] cmdDevAddr = 4'h1;
  logic [2:0] cmdPage = 3'h0;
  logic [5:0] cmdAddr = 6'h00;
  logic [13:0] cmdWdata = 14'h0000;
  logic dnWakeClk = 1'b0;
  logic ackOn = 1'b1;
  logic upLinkClk, upLinkAck, rspValid_ff, fwdValid_ff, wakeClkOut_ff, cellBalanceOn_ff;
  logic registerCheckFault_ff, scanHalt_ff, asleep_ff, watchdogFault_ff;
  logic [5:0] rspCode_ff;
  logic [13:0] rspData_ff, shadow;
  // Row: write, device, page, address, answer mode (0 none, 1 code, 2 any), code, balance, fault
  logic [39:0] rows[14] = '{40'h0130C10C00, 40'h1130C10B00, 40'h0130D10B00, 40'h1120010B00,
    40'h0131011010, 40'h0F31100000, 40'h0F31000010, 40'h0130920010, 40'h1120020010,
    40'h0131311310, 40'h0131411410, 40'h1120020010, 40'h0131411411, 40'h0130C10C11};
  int fail_count = 0;
  int tests_run = 0;
  int n = 0;
  bit got;
  always #2 clock = ~clock;
  always @(wakeClkOut_ff) n++;
  sch_stack_cmd #(.NV_REF_SUM(14'h0123), .WDOG_CYC(32'h12C)) sch_stack_cmd_i (.clock(clock),
    .rst_n(rst_n), .myDevAddr(4'h1), .isMaster(1'b1), .isTop(1'b1), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdDevAddr(cmdDevAddr), .cmdPage(cmdPage), .cmdAddr(cmdAddr),
    .cmdWdata(cmdWdata), .rspValid_ff(rspValid_ff), .rspCode_ff(rspCode_ff),
    .rspData_ff(rspData_ff), .fwdValid_ff(fwdValid_ff), .upLinkClk(upLinkClk),
    .upLinkAck(upLinkAck), .wakeClkOut_ff(wakeClkOut_ff), .dnWakeClk(dnWakeClk),
    .cellBalanceOn_ff(cellBalanceOn_ff), .registerCheckFault_ff(registerCheckFault_ff),
    .scanHalt_ff(scanHalt_ff), .asleep_ff(asleep_ff), .watchdogFault_ff(watchdogFault_ff));
  sch_uplink_model sch_uplink_model_i (.fwdValid(fwdValid_ff), .ackOn(ackOn),
    .linkClk(upLinkClk), .linkAck(upLinkAck));
  task automatic chk(string name, logic [13:0] exp, logic [13:0] seen);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Frame is offered for exactly one cycle; returns at its taking edge
  task automatic send(logic w, logic [3:0] d, logic [2:0] p, logic [5:0] a, logic [13:0] wd);
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdWrite <= w;
    cmdDevAddr <= d;
    cmdPage <= p;
    cmdAddr <= a;
    cmdWdata <= wd;
    @(posedge clock);
    cmdValid <= 1'b0;
  endtask
  task automatic waitRsp(int cycles, output bit seen);
    seen = 1'b0;
    repeat (cycles) begin
      #1;
      if (rspValid_ff === 1'b1) begin
        seen = 1'b1;
        return;
      end
      @(posedge clock);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (12) @(posedge clock);
    send(1'b0, 4'h1, 3'h4, 6'h3F, 14'h0000);
    waitRsp(4, got);
    chk("reference", 14'h0123, rspData_ff);
    send(1'b0, 4'h1, 3'h5, 6'h00, 14'h0000);
    waitRsp(4, got);
    shadow = rspData_ff;
    $display("checksum reads done");
    foreach (rows[i]) begin
      send(rows[i][36], rows[i][35:32], rows[i][30:28], rows[i][25:20], 14'(i));
      waitRsp(12, got);
      if (rows[i][19:16] != 4'h2) chk("answer", rows[i][16], got);
      if (rows[i][16]) chk("code", rows[i][13:8], rspCode_ff);
      repeat (12) @(posedge clock);
      chk("balance", rows[i][4], cellBalanceOn_ff);
      chk("fault", rows[i][0], registerCheckFault_ff);
      $display("row %0d done", i);
    end
    send(1'b0, 4'h1, 3'h3, `SCH_CMD_RESET, 14'h0000);
    #1 chk("halt", 1'b1, scanHalt_ff);
    repeat (20) @(posedge clock);
    chk("balance", 1'b0, cellBalanceOn_ff);
    chk("fault", 1'b0, registerCheckFault_ff);
    send(1'b0, 4'h1, 3'h5, 6'h00, 14'h0000);
    waitRsp(4, got);
    chk("shadow", shadow, rspData_ff);
    send(1'b1, 4'h1, 3'h2, 6'h01, 14'h0055);
    waitRsp(4, got);
    chk("nak", `SCH_CMD_NAK, rspCode_ff);
    send(1'b0, 4'h1, 3'h3, `SCH_CMD_IDENTIFY, 14'h0000);
    repeat (12) @(posedge clock);
    send(1'b1, 4'h1, 3'h2, 6'h01, 14'h0055);
    waitRsp(4, got);
    chk("resend", 14'h0001, rspCode_ff);
    send(1'b0, 4'h1, 3'h2, 6'h01, 14'h0000);
    waitRsp(4, got);
    chk("readback", 14'h0055, rspData_ff);
    $display("reset test done");
    send(1'b0, 4'h3, 3'h3, `SCH_CMD_ACK, 14'h0000);
    waitRsp(2600, got);
    chk("answer", 1'b0, got);
    ackOn <= 1'b0;
    send(1'b0, 4'h3, 3'h3, `SCH_CMD_ACK, 14'h0000);
    waitRsp(2600, got);
    chk("code", `SCH_CMD_COMM_FAIL, rspCode_ff);
    chk("watchdog", 1'b1, watchdogFault_ff);
    $display("forward test done");
    send(1'b0, 4'h1, 3'h3, `SCH_CMD_WAKEUP, 14'h0000);
    n = 0;
    repeat (17000) @(posedge clock);
    chk("toggles", 14'h0010, 14'(n));
    send(1'b0, 4'h1, 3'h3, `SCH_CMD_SLEEP, 14'h0000);
    repeat (12) @(posedge clock);
    chk("asleep", 1'b1, asleep_ff);
    // Wake clock from below, driven on clock edges; ends high on its fourth rise
    repeat (4) begin
      repeat (16) @(posedge clock);
      dnWakeClk <= 1'b0;
      repeat (16) @(posedge clock);
      dnWakeClk <= 1'b1;
    end
    waitRsp(200, got);
    chk("code", `SCH_CMD_ACK, rspCode_ff);
    chk("answer", 1'b1, got);
    @(posedge clock);
    dnWakeClk <= 1'b0;
    chk("asleep", 1'b0, asleep_ff);
    chk("watchdog", 1'b0, watchdogFault_ff);
    $display("wake test done");
    stop_test;
  end
  initial begin
    #400000;
    fail_count++;
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
